// file: rtl/ssmio_host.sv
// Host end of the serial SRAM link with its write-data FIFO.
// Assumes one request at a time from user logic; read data is not back-pressured.
`timescale 1ns/1ps
`default_nettype none
`include "ssmio_regs.svh"

// ==========================================================================
// Write-data FIFO
module ssmio_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} ssmio_fstate_t;

	ssmio_fstate_t    q;
	ssmio_fstate_t    d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	// Wrap pointers by hand so any depth works
	function automatic logic [AW-1:0] ptr_bump(logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : ptr_bump

	assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (q.cnt != '0);
	assign out_data  = mem[q.rp];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointer and fill count
	always_comb begin
		d = q;
		if (push) begin
			d.wp = ptr_bump(q.wp);
		end
		if (pop) begin
			d.rp = ptr_bump(q.rp);
		end
		if (push && !pop) begin
			d.cnt = q.cnt + 1'b1;
		end else if (pop && !push) begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[q.wp] <= in_data;
		end
	end
endmodule : ssmio_fifo

// ==========================================================================
// Host sequencer
module ssmio_host import ssmio_pkg::*; #(
	parameter int SCK_HALF   = `SSMIO_SCK_HALF_CYC,
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	ssmio_if.host            link,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire ssmio_op_t   req_op,
	input  wire logic [16:0] req_addr,
	input  wire logic [15:0] req_len,
	input  wire logic        wr_valid,
	output logic             wr_ready,
	input  wire logic [7:0]  wr_data,
	output logic             rd_valid,
	output logic [7:0]       rd_data,
	output ssmio_io_t        bus_form
);
	typedef enum logic [2:0] {H_IDLE, H_SHIFT, H_LOAD, H_TAIL, H_GAP} ssmio_hst_t;

	typedef struct packed {
		ssmio_hst_t st;
		ssmio_io_t  io;
		ssmio_op_t  op;
		logic       cs_n;
		logic       sck;
		logic [7:0] div;
		logic [31:0] sh;
		logic [5:0] left;
		logic [15:0] bytes;
		logic       hdr;
		logic [7:0] rx;
		logic       rd_valid;
		logic [7:0] rd_data;
		logic [3:0] oe;
	} ssmio_hstate_t;

	localparam ssmio_hstate_t Q_RST = '{
		st: H_IDLE, io: SSMIO_IO_SINGLE, op: SSMIO_OP_READ, cs_n: 1'b1, sck: 1'b0,
		div: 8'h00, sh: 32'h0, left: 6'h00, bytes: 16'h0000, hdr: 1'b0, rx: 8'h00,
		rd_valid: 1'b0, rd_data: 8'h00, oe: 4'h0
	};

	ssmio_hstate_t q;
	ssmio_hstate_t d;
	logic          tick;
	logic          recv;
	logic          wide;
	logic [5:0]    w6;
	logic [3:0]    lane_in;
	logic          f_valid;
	logic [7:0]    f_data;
	logic          pop;

	function automatic logic [7:0] opcode(ssmio_op_t op);
		unique case (op)
		SSMIO_OP_WRITE:  return `SSMIO_OPC_WRITE;
		SSMIO_OP_MREAD:  return `SSMIO_OPC_MREAD;
		SSMIO_OP_MWRITE: return `SSMIO_OPC_MWRITE;
		SSMIO_OP_DUAL:   return `SSMIO_OPC_DUAL;
		SSMIO_OP_QUAD:   return `SSMIO_OPC_QUAD;
		SSMIO_OP_LEAVE:  return `SSMIO_OPC_LEAVE;
		default:         return `SSMIO_OPC_READ;
		endcase
	endfunction : opcode

	ssmio_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_data),
		.out_valid (f_valid),
		.out_ready (pop),
		.out_data  (f_data)
	);

	assign tick    = (q.div == 8'(SCK_HALF - 1));
	assign recv    = (q.op == SSMIO_OP_READ) || (q.op == SSMIO_OP_MREAD);
	assign wide    = (req_op == SSMIO_OP_READ) || (req_op == SSMIO_OP_WRITE);
	assign w6      = {2'h0, ssmio_width(q.io)};
	// Single form listens on lane 1 only
	assign lane_in = {link.sio[3:1], (q.io == SSMIO_IO_SINGLE) ? link.sio[1] : link.sio[0]};
	assign pop     = (q.st == H_LOAD) && f_valid;

	// Sequencer; the serial clock is a divided clk_sys
	always_comb begin
		d          = q;
		d.rd_valid = 1'b0;
		d.div      = tick ? 8'h00 : q.div + 8'h01;
		unique case (q.st)
		H_IDLE: begin
			d.div = 8'h00;
			if (req_valid) begin
				d.op    = req_op;
				d.cs_n  = 1'b0;
				d.hdr   = 1'b1;
				d.sh    = {opcode(req_op), 7'h00, req_addr};
				d.left  = wide ? 6'h20 : 6'h08;
				d.bytes = wide ? req_len : ((req_op == SSMIO_OP_MREAD ||
					req_op == SSMIO_OP_MWRITE) ? 16'h0001 : 16'h0000);
				d.oe    = ssmio_oe(q.io, 1'b0);
				d.st    = H_SHIFT;
			end
		end
		H_SHIFT: begin
			if (tick && !q.sck) begin
				d.sck = 1'b1;
				d.rx  = ssmio_shift8(q.io, q.rx, lane_in);
			end else if (tick) begin
				d.sck  = 1'b0;
				d.sh   = q.sh << w6;
				d.left = q.left - w6;
				if (q.left == w6) begin
					d.hdr = 1'b0;
					if (!q.hdr && recv) begin
						d.rd_valid = 1'b1;
						d.rd_data  = q.rx;
					end
					if (q.bytes == 16'h0000) begin
						d.st = H_TAIL;
					end else if (recv) begin
						// Release the lanes on the same fall the device starts driving
						d.bytes = q.bytes - 16'h0001;
						d.left  = 6'h08;
						d.oe    = 4'h0;
					end else begin
						d.bytes = q.bytes - 16'h0001;
						d.st    = H_LOAD;
					end
				end
			end
		end
		H_LOAD: begin
			// Empty FIFO stalls with the clock parked low and select held
			d.div = 8'h00;
			if (f_valid) begin
				d.sh   = {f_data, 24'h000000};
				d.left = 6'h08;
				d.st   = H_SHIFT;
			end
		end
		H_TAIL: begin
			if (tick) begin
				d.cs_n = 1'b1;
				d.oe   = 4'h0;
				d.st   = H_GAP;
				if (q.op == SSMIO_OP_DUAL) begin
					d.io = SSMIO_IO_DUAL;
				end else if (q.op == SSMIO_OP_QUAD) begin
					d.io = SSMIO_IO_QUAD;
				end else if (q.op == SSMIO_OP_LEAVE) begin
					d.io = SSMIO_IO_SINGLE;
				end
			end
		end
		H_GAP: begin
			if (tick) begin
				d.st = H_IDLE;
			end
		end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= Q_RST;
		end else begin
			q <= d;
		end
	end

	// Outputs
	assign link.cs_n    = q.cs_n;
	assign link.sck     = q.sck;
	assign link.host_o  = ssmio_lanes(q.io, q.sh[31:28]);
	assign link.host_oe = q.oe;
	assign req_ready    = (q.st == H_IDLE);
	assign rd_valid     = q.rd_valid;
	assign rd_data      = q.rd_data;
	assign bus_form     = q.io;
endmodule : ssmio_host

`default_nettype wire

// file: rtl/ssmio_regs.svh
// Constants for the serial SRAM link: opcodes, mode field, array size, link timing.
// Assumes inclusion by bare name from rtl/; definitions only.
`ifndef SSMIO_REGS_SVH
`define SSMIO_REGS_SVH

// ==========================================================================
// Opcodes
`define SSMIO_OPC_READ    8'h03
`define SSMIO_OPC_WRITE   8'h02
`define SSMIO_OPC_DUAL    8'h3B
`define SSMIO_OPC_QUAD    8'h38
`define SSMIO_OPC_LEAVE   8'hFF
`define SSMIO_OPC_MREAD   8'h05
`define SSMIO_OPC_MWRITE  8'h01

// ==========================================================================
// Mode register field
`define SSMIO_MODE_HI     7
`define SSMIO_MODE_LO     6
`define SSMIO_AM_BYTE     2'h0
`define SSMIO_AM_SEQ      2'h1
`define SSMIO_AM_PAGE     2'h2
`define SSMIO_AM_RSVD     2'h3
`define SSMIO_MODE_RST    `SSMIO_AM_SEQ

// ==========================================================================
// Array geometry
`define SSMIO_ADDR_W      17
`define SSMIO_PAGE_W      5
`define SSMIO_MEM_BYTES   131072

// ==========================================================================
// Link timing
`define SSMIO_CLK_NS      25
`define SSMIO_SCK_HALF_NS 50
`define SSMIO_SCK_HALF_CYC ((`SSMIO_SCK_HALF_NS + `SSMIO_CLK_NS - 1) / `SSMIO_CLK_NS)

`endif

// file: rtl/ssmio_pkg.sv
// Types and lane helpers shared by both ends of the serial SRAM link.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package ssmio_pkg;

	// ======================================================================
	// Types
	typedef enum logic [1:0] {SSMIO_IO_SINGLE, SSMIO_IO_DUAL, SSMIO_IO_QUAD} ssmio_io_t;
	typedef enum logic [2:0] {
		SSMIO_OP_READ, SSMIO_OP_WRITE, SSMIO_OP_MREAD, SSMIO_OP_MWRITE,
		SSMIO_OP_DUAL, SSMIO_OP_QUAD, SSMIO_OP_LEAVE
	} ssmio_op_t;

	// ======================================================================
	// Lane helpers
	// Bits carried per serial clock
	function automatic logic [3:0] ssmio_width(ssmio_io_t m);
		unique case (m)
		SSMIO_IO_DUAL: return 4'h2;
		SSMIO_IO_QUAD: return 4'h4;
		default:       return 4'h1;
		endcase
	endfunction : ssmio_width

	// Shift incoming lanes in, oldest bit ends up most significant
	function automatic logic [7:0] ssmio_shift8(ssmio_io_t m, logic [7:0] sh, logic [3:0] b);
		unique case (m)
		SSMIO_IO_DUAL: return {sh[5:0], b[1:0]};
		SSMIO_IO_QUAD: return {sh[3:0], b[3:0]};
		default:       return {sh[6:0], b[0]};
		endcase
	endfunction : ssmio_shift8

	// Top bits of a value onto the lanes; single form copies to lanes 0 and 1
	function automatic logic [3:0] ssmio_lanes(ssmio_io_t m, logic [3:0] t);
		unique case (m)
		SSMIO_IO_DUAL: return {2'h0, t[3:2]};
		SSMIO_IO_QUAD: return t;
		default:       return {2'h0, t[3], t[3]};
		endcase
	endfunction : ssmio_lanes

	// Lanes an end drives while sending; single form: host lane 0, device lane 1
	function automatic logic [3:0] ssmio_oe(ssmio_io_t m, logic dev);
		unique case (m)
		SSMIO_IO_DUAL: return 4'h3;
		SSMIO_IO_QUAD: return 4'hF;
		default:       return dev ? 4'h2 : 4'h1;
		endcase
	endfunction : ssmio_oe

endpackage : ssmio_pkg

`default_nettype wire

// file: rtl/ssmio_if.sv
// Link between host and serial SRAM: select, serial clock, four data lanes.
// Assumes both ends run on the same system clock; lanes resolved here.
`timescale 1ns/1ps
`default_nettype none

interface ssmio_if;
	logic       cs_n;
	logic       sck;
	logic [3:0] host_o;
	logic [3:0] host_oe;
	logic [3:0] dev_o;
	logic [3:0] dev_oe;
	logic [3:0] sio;

	// ======================================================================
	// Lane level; an undriven lane reads high, as with a pull-up
	assign sio = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) | (~dev_oe & ~host_oe);

	modport host (output cs_n, output sck, output host_o, output host_oe, input sio);
	modport dev  (input cs_n, input sck, input sio, output dev_o, output dev_oe);
endinterface : ssmio_if

`default_nettype wire

// file: rtl/ssmio_dev.sv
// Serial SRAM end of the link: opcode and address decode, 128K x 8 array, mode field.
// Assumes serial clock and select arrive synchronous to clk_sys and change
// no faster than once every two clk_sys cycles.
//
// How it works
// - Single form: input sampled on clock rise
// - Opcode gathered into eight-bit register first
// - Host holds select low through whole operation
// - All values shift most significant first
// - Dual form: two lanes, two bits per clock
// - Quad form: four lanes, four bits per clock
// - Address advance chosen by mode bits 7:6
// - Mode 00: one byte per access
// - Mode 10: increment within 32-byte page
// - Page end wraps to same page start
// - Mode 01: increment across whole array
// - Read: opcode, then 24-bit address
// - After read address, stored byte shifted out
// - Sequential read rolls 1FFFFh over to 0
// - Select high ends read, outputs released
// - Fixed opcode values for all seven commands
// - Output changes after serial clock falls
// - Mode defaults sequential; 11 is refused
// - Write: opcode, address, data bytes
`timescale 1ns/1ps
`default_nettype none
`include "ssmio_regs.svh"

module ssmio_dev import ssmio_pkg::*; #(
	parameter int MEM_BYTES = `SSMIO_MEM_BYTES
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	ssmio_if.dev            link,
	output logic [1:0]      addr_mode,
	output ssmio_io_t       bus_form,
	output logic            selected
);

	// ======================================================================
	// State
	typedef enum logic [2:0] {D_CMD, D_ADDR, D_RD, D_WR, D_MRD, D_MWR, D_SKIP} ssmio_dst_t;

	typedef struct packed {
		ssmio_dst_t st;
		ssmio_io_t  io;
		logic [1:0] amode;
		logic       sck;
		logic       sel;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic [1:0] nb;
		logic [7:0] cmd;
		logic [`SSMIO_ADDR_W-1:0] addr;
		logic [7:0] osh;
		logic [3:0] ocnt;
		logic [3:0] dout;
		logic [3:0] oe;
	} ssmio_dstate_t;

	localparam ssmio_dstate_t Q_RST = '{
		st: D_CMD, io: SSMIO_IO_SINGLE, amode: `SSMIO_MODE_RST,
		sck: 1'b0, sel: 1'b0, sh: 8'h00, cnt: 4'h0, nb: 2'h0, cmd: 8'h00,
		addr: '0, osh: 8'h00, ocnt: 4'h0, dout: 4'h0, oe: 4'h0
	};

	ssmio_dstate_t q;
	ssmio_dstate_t d;
	logic [7:0]    mem [MEM_BYTES];
	logic          rise;
	logic          fall;
	logic [3:0]    w;
	logic [7:0]    nsh;
	logic [3:0]    ncnt;
	logic [3:0]    nocnt;
	logic [7:0]    obyte;
	logic          wr_en;

	// ======================================================================
	// Address advance
	// Page form keeps the upper bits and lets the low five wrap
	function automatic logic [`SSMIO_ADDR_W-1:0] next_addr(logic [1:0] am,
		logic [`SSMIO_ADDR_W-1:0] a);
		if (am == `SSMIO_AM_PAGE) begin
			return {a[`SSMIO_ADDR_W-1:`SSMIO_PAGE_W], a[`SSMIO_PAGE_W-1:0] + 1'b1};
		end
		return a + 1'b1;
	endfunction : next_addr

	// ======================================================================
	// Edge detect on the serial clock, sampled as a plain synchronous input
	assign rise = link.sck & ~q.sck;
	assign fall = ~link.sck & q.sck;

	// ======================================================================
	// Next state
	always_comb begin
		d      = q;
		wr_en  = 1'b0;
		w      = ssmio_width(q.io);
		nsh    = ssmio_shift8(q.io, q.sh, link.sio);
		ncnt   = q.cnt + w;
		nocnt  = q.ocnt + w;
		// First slice of a byte comes straight from the array or mode field
		if (q.ocnt != 4'h0) begin
			obyte = q.osh;
		end else if (q.st == D_RD) begin
			obyte = mem[q.addr];
		end else begin
			obyte = {q.amode, 6'h00};
		end
		d.sck  = link.sck;
		d.sel  = ~link.cs_n;
		if (link.cs_n) begin
			// Deselect aborts any sequence and floats the lanes
			d.st   = D_CMD;
			d.cnt  = 4'h0;
			d.nb   = 2'h0;
			d.ocnt = 4'h0;
			d.oe   = 4'h0;
		end else if (rise && (q.st inside {D_CMD, D_ADDR, D_WR, D_MWR})) begin
			d.sh  = nsh;
			d.cnt = ncnt;
			if (ncnt == 4'h8) begin
				d.cnt = 4'h0;
				unique case (q.st)
				D_CMD: begin
					d.cmd = nsh;
					d.nb  = 2'h0;
					// Unknown opcodes are swallowed until deselect
					case (nsh)
					`SSMIO_OPC_READ:   d.st = D_ADDR;
					`SSMIO_OPC_WRITE:  d.st = D_ADDR;
					`SSMIO_OPC_MREAD:  d.st = D_MRD;
					`SSMIO_OPC_MWRITE: d.st = D_MWR;
					`SSMIO_OPC_DUAL: begin
						d.io = SSMIO_IO_DUAL;
						d.st = D_SKIP;
					end
					`SSMIO_OPC_QUAD: begin
						d.io = SSMIO_IO_QUAD;
						d.st = D_SKIP;
					end
					`SSMIO_OPC_LEAVE: begin
						d.io = SSMIO_IO_SINGLE;
						d.st = D_SKIP;
					end
					default: d.st = D_SKIP;
					endcase
				end
				D_ADDR: begin
					// Three bytes in; the seven top bits drop off the end
					d.addr = {q.addr[`SSMIO_ADDR_W-9:0], nsh};
					d.nb   = q.nb + 2'h1;
					if (q.nb == 2'h2) begin
						d.st = (q.cmd == `SSMIO_OPC_READ) ? D_RD : D_WR;
					end
				end
				D_WR: begin
					wr_en  = 1'b1;
					d.addr = next_addr(q.amode, q.addr);
					if (q.amode == `SSMIO_AM_BYTE) begin
						d.st = D_SKIP;
					end
				end
				D_MWR: begin
					// Reserved code leaves the field as it was
					if (nsh[`SSMIO_MODE_HI:`SSMIO_MODE_LO] != `SSMIO_AM_RSVD) begin
						d.amode = nsh[`SSMIO_MODE_HI:`SSMIO_MODE_LO];
					end
					d.st = D_SKIP;
				end
				endcase
			end
		end else if (fall && (q.st == D_RD || q.st == D_MRD)) begin
			// Drive on the fall so the host sees it settled at the next rise
			d.dout = ssmio_lanes(q.io, obyte[7:4]);
			d.oe   = ssmio_oe(q.io, 1'b1);
			d.osh  = obyte << w;
			d.ocnt = nocnt;
			if (nocnt == 4'h8) begin
				d.ocnt = 4'h0;
				if (q.st == D_RD) begin
					d.addr = next_addr(q.amode, q.addr);
				end
				if (q.st == D_MRD || q.amode == `SSMIO_AM_BYTE) begin
					d.st = D_SKIP;
				end
			end
		end else if (fall && q.st == D_SKIP) begin
			d.oe = 4'h0;
		end
	end

	// ======================================================================
	// Registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= Q_RST;
		end else begin
			q <= d;
		end
	end

	// Array holds no reset; contents are unknown after power-up anyway
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[q.addr] <= nsh;
		end
	end

	// ======================================================================
	// Outputs
	assign link.dev_o  = q.dout;
	assign link.dev_oe = q.oe;
	assign addr_mode   = q.amode;
	assign bus_form    = q.io;
	assign selected    = q.sel;

endmodule : ssmio_dev

`default_nettype wire

// file: testbench/ssmio_assertions.sv
// Protocol checks on the serial SRAM link between the host and device ends.
// Assumes the bench instantiates it beside the interface and hands over its signals.
`timescale 1ns/1ps
`default_nettype none

module ssmio_assertions (
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic       cs_n,
	input wire logic       sck,
	input wire logic [3:0] host_o,
	input wire logic [3:0] host_oe,
	input wire logic [3:0] dev_o,
	input wire logic [3:0] dev_oe,
	input wire logic [3:0] sio
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// ==========
	// Framing: select edges only while the serial clock rests low
	a_idle_clock_low: assert property (cs_n |-> !sck)
		else $error("serial clock high while deselected");
	a_frame_edge_quiet: assert property ($changed(cs_n) |-> !sck && !$past(sck))
		else $error("select moved around a serial clock pulse");
	a_release_on_deselect: assert property ($rose(cs_n) |-> ##[1:2] dev_oe == 4'h0)
		else $error("device still drives lanes after deselect");

	// ==========
	// Serial clock shape; device needs two system clocks per level
	a_clock_high_width: assert property ($rose(sck) |-> sck [*2] ##1 !sck)
		else $error("serial clock high phase not two cycles");
	a_clock_low_width: assert property ($fell(sck) |-> !sck [*2])
		else $error("serial clock low phase too short");

	// ==========
	// Data lanes: sender moves data only while the clock is low
	a_dev_change_on_low: assert property (
		$changed(dev_o) && dev_oe != 4'h0 |-> !sck && !$past(sck))
		else $error("device data moved outside the low phase");
	a_host_hold_high: assert property (!cs_n && sck && host_oe != 4'h0 |-> $stable(host_o))
		else $error("host data moved while clock high");
	a_no_contention: assert property ((dev_oe & host_oe) == 4'h0)
		else $error("both ends drive the same lane");
	a_lane_sets: assert property (
		dev_oe inside {4'h0, 4'h2, 4'h3, 4'hF} && host_oe inside {4'h0, 4'h1, 4'h3, 4'hF})
		else $error("lane enable pattern fits no bus form");

	// ==========
	// Main traffic seen
	cover property (dev_oe == 4'hF && sio == dev_o);
	cover property (dev_oe == 4'h3);
	cover property ($rose(cs_n) && dev_oe != 4'h0);
endmodule : ssmio_assertions

`default_nettype wire

// file: testbench/serial_sram_multi_io_access_bench.sv
// Self-checking bench: host end and device end joined by the link interface.
// Assumes rtl/ is on the include path; drives only the host user side.
`timescale 1ns/1ps
`default_nettype none
`include "ssmio_regs.svh"

module serial_sram_multi_io_access_bench import ssmio_pkg::*;;
	logic        clk_sys, rst_n, sck_prev, was_single, selected;
	logic        req_valid, req_ready, wr_valid, wr_ready, rd_valid;
	ssmio_op_t   req_op;
	logic [16:0] req_addr;
	logic [15:0] req_len;
	logic [7:0]  wr_data, rd_data, opc_seen;
	logic [1:0]  addr_mode, mode_exp;
	ssmio_io_t   dev_form, host_form;
	int          fails, n_checks, bit_cnt;
	logic [7:0]  exp_mem [int];
	logic [7:0]  rdq [$];

	// ==========
	// Both ends and the checker
	ssmio_if i_ssmio_if ();
	ssmio_dev i_ssmio_dev (.clk_sys(clk_sys), .rst_n(rst_n), .link(i_ssmio_if.dev),
		.addr_mode(addr_mode), .bus_form(dev_form), .selected(selected));
	ssmio_host i_ssmio_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(i_ssmio_if.host),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
		.req_len(req_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.rd_valid(rd_valid), .rd_data(rd_data), .bus_form(host_form));
	ssmio_assertions i_ssmio_assertions (.clk_sys(clk_sys), .rst_n(rst_n),
		.cs_n(i_ssmio_if.cs_n), .sck(i_ssmio_if.sck), .host_o(i_ssmio_if.host_o),
		.host_oe(i_ssmio_if.host_oe), .dev_o(i_ssmio_if.dev_o), .dev_oe(i_ssmio_if.dev_oe),
		.sio(i_ssmio_if.sio));

	// 40 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Mid-cycle sampling keeps clear of edge races
	always @(negedge clk_sys) begin
		if (rd_valid === 1'b1)
			rdq.push_back(rd_data);
		if (i_ssmio_if.cs_n !== 1'b0)
			bit_cnt = 0;
		else if (i_ssmio_if.sck === 1'b1 && sck_prev === 1'b0 && bit_cnt < 8) begin
			opc_seen = {opc_seen[6:0], i_ssmio_if.sio[0]};
			bit_cnt++;
		end
		sck_prev = i_ssmio_if.sck;
	end

	// ==========
	// Expectations and comparisons
	function automatic logic [7:0] code_of(ssmio_op_t o);
		case (o)
		SSMIO_OP_READ:   return `SSMIO_OPC_READ;
		SSMIO_OP_WRITE:  return `SSMIO_OPC_WRITE;
		SSMIO_OP_MREAD:  return `SSMIO_OPC_MREAD;
		SSMIO_OP_MWRITE: return `SSMIO_OPC_MWRITE;
		SSMIO_OP_DUAL:   return `SSMIO_OPC_DUAL;
		SSMIO_OP_QUAD:   return `SSMIO_OPC_QUAD;
		default:         return `SSMIO_OPC_LEAVE;
		endcase
	endfunction : code_of

	// Page mode keeps the upper bits; otherwise wrap over the whole array
	function automatic logic [16:0] nxt(logic [16:0] a);
		if (mode_exp == `SSMIO_AM_PAGE)
			return {a[16:5], a[4:0] + 5'h01};
		return a + 17'h00001;
	endfunction : nxt

	task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk8

	task automatic chkf(string what, ssmio_io_t exp);
		n_checks++;
		if (dev_form !== exp || host_form !== exp) begin
			fails++;
			$display("mismatch %s expected %s seen %s %s", what, exp.name(), dev_form.name(),
				host_form.name());
		end
	endtask : chkf

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// ==========
	// User-side drivers; every call starts one tick past a rising edge
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask : tick

	// Valid stays high until the caller drops it
	task automatic push(logic [7:0] d);
		wr_valid = 1'b1;
		wr_data  = d;
		while (wr_ready !== 1'b1)
			tick();
		tick();
	endtask : push

	task automatic go(ssmio_op_t o, logic [16:0] a, int len);
		rdq.delete();
		was_single = (host_form === SSMIO_IO_SINGLE);
		req_valid  = 1'b1;
		req_op     = o;
		req_addr   = a;
		req_len    = 16'(len);
		while (req_ready !== 1'b1)
			tick();
		tick();
		req_valid = 1'b0;
		// Device registers the select one clock after the host lowers it
		tick();
		chk8("select seen", 8'h01, {7'h0, selected});
	endtask : go

	task automatic done(ssmio_op_t o);
		for (int t = 0; t < 4000 && req_ready !== 1'b1; t++)
			tick();
		chk8("completion", 8'h01, {7'h0, req_ready});
		chk8("select released", 8'h00, {7'h0, selected});
		if (was_single)
			chk8("opcode on wire", code_of(o), opc_seen);
	endtask : done

	task automatic op(ssmio_op_t o, logic [16:0] a, int len);
		go(o, a, len);
		done(o);
	endtask : op

	// Late mode starts the access after one byte, so the host stalls on an empty FIFO
	task automatic wr(logic [16:0] a, int n, bit late);
		logic [16:0] p;
		logic [7:0]  d;
		p = a;
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			if (late && i == 1) begin
				wr_valid = 1'b0;
				go(SSMIO_OP_WRITE, a, n);
				repeat (200) tick();
			end
			push(d);
			if (i == 0 || mode_exp != `SSMIO_AM_BYTE)
				exp_mem[p] = d;
			p = nxt(p);
		end
		wr_valid = 1'b0;
		if (n == 8)
			chk8("fifo full", 8'h00, {7'h0, wr_ready});
		if (!late)
			go(SSMIO_OP_WRITE, a, n);
		done(SSMIO_OP_WRITE);
	endtask : wr

	task automatic rd(logic [16:0] a, int n);
		logic [7:0] e;
		op(SSMIO_OP_READ, a, n);
		chk8("read count", 8'(n), 8'(rdq.size()));
		for (int i = 0; i < n; i++) begin
			// Byte mode: device falls quiet after one byte, pull-ups show
			e = (i > 0 && mode_exp == `SSMIO_AM_BYTE) ? 8'hFF : exp_mem[a];
			chk8("read byte", e, rdq[i]);
			a = nxt(a);
		end
	endtask : rd

	task automatic setmode(logic [1:0] m);
		push({m, 6'h00});
		wr_valid = 1'b0;
		op(SSMIO_OP_MWRITE, 17'h00000, 1);
		if (m != `SSMIO_AM_RSVD)
			mode_exp = m;
		chk8("mode field", {6'h00, mode_exp}, {6'h00, addr_mode});
		op(SSMIO_OP_MREAD, 17'h00000, 1);
		chk8("mode read", {mode_exp, 6'h00}, rdq[0]);
	endtask : setmode

	// ==========
	// Main sequence
	initial begin
		logic [16:0] a;
		rst_n     = 1'b0;
		req_valid = 1'b0;
		req_op    = SSMIO_OP_READ;
		req_addr  = 17'h00000;
		req_len   = 16'h0000;
		wr_valid  = 1'b0;
		wr_data   = 8'h00;
		mode_exp  = `SSMIO_AM_SEQ;
		fails     = 0;
		n_checks  = 0;
		bit_cnt   = 0;
		sck_prev  = 1'b0;
		opc_seen  = 8'h00;
		void'($urandom(32'h0cc9558c));
		repeat (2) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		chk8("reset mode", {6'h00, `SSMIO_AM_SEQ}, {6'h00, addr_mode});
		chkf("reset form", SSMIO_IO_SINGLE);
		setmode(`SSMIO_AM_SEQ);
		$display("test reset done");
		wr(17'h1FFFC, 8, 1'b0);
		rd(17'h1FFFC, 8);
		$display("test sequential done");
		setmode(`SSMIO_AM_PAGE);
		a = {12'($urandom), 5'h1E};
		wr(a, 4, 1'b1);
		rd(a, 4);
		$display("test page done");
		setmode(`SSMIO_AM_BYTE);
		a = 17'($urandom);
		wr(a, 2, 1'b0);
		rd(a, 2);
		setmode(`SSMIO_AM_RSVD);
		setmode(`SSMIO_AM_SEQ);
		$display("test byte done");
		for (int f = 1; f < 3; f++) begin
			a = 17'($urandom);
			op(f == 1 ? SSMIO_OP_DUAL : SSMIO_OP_QUAD, 17'h00000, 0);
			chkf("wide form", ssmio_io_t'(f));
			wr(a, 5, 1'b0);
			rd(a, 5);
			op(SSMIO_OP_LEAVE, 17'h00000, 0);
			chkf("single form", SSMIO_IO_SINGLE);
			rd(a, 5);
		end
		$display("test wide forms done");
		final_report();
	end

	// Watchdog, several times the expected run length
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		final_report();
	end
endmodule : serial_sram_multi_io_access_bench

`default_nettype wire
